// ### core/asx_core.sv
// apb-reached execution unit: subtract, nibble swap, exclusive-or and power-down
// assumes a 32-bit apb master on I_CLOCK; zero wait states, pready always high
//
// Behaviour
// - register minus accumulator in two's complement over registers 0..127, updates flags
// - destination bit 0 writes accumulator, 1 writes the addressed register back
// - literal minus accumulator always lands in the accumulator, updates carry, half, zero
// - carry and half carry clear on borrow, set otherwise
// - power-down clears the power-down flag and sets the time-out flag
// - power-down clears watchdog counter and its prescaler
// - power-down halts the oscillator and alters only time-out and power-down flags
// - nibble swap exchanges upper and lower halves, no flags change
// - xor literal with accumulator into accumulator, only zero flag changes
// - xor register with accumulator to chosen destination, only zero flag changes
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module asx_core
(
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_OSC_RUN
);
  logic [7:0] data_file [asx_pkg::FILE_DEPTH];
  logic [7:0] acc;
  logic carry;
  logic half_carry;
  logic zero;
  logic power_down_flag;
  logic time_out_flag;
  logic sleeping;
  logic [31:0] cmd_last;
  logic [7:0] wd_prescaler;
  logic [7:0] wd_count;

  logic setup;
  logic access;
  logic wr;
  logic aligned;
  logic hit_cmd;
  logic hit_acc;
  logic hit_status;
  logic hit_wdog;
  logic hit_file;
  logic mapped;
  logic exec;
  logic refused;
  logic [6:0] file_idx;

  asx_pkg::asx_op_e cmd_op;
  logic cmd_dest;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_lit;
  logic [7:0] fval;

  logic [7:0] alu_res;
  logic alu_carry;
  logic alu_half;
  logic alu_upd_carry;
  logic alu_upd_zero;
  logic alu_reg_source;
  logic to_acc;
  logic to_file;
  logic sleep_exec;
  logic [31:0] next_prdata;

  // apb decode
  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign wr = access && I_PWRITE;
  assign aligned = (I_PADDR[1:0] == 2'b00);
  assign hit_cmd = (I_PADDR == asx_pkg::REG_CMD);
  assign hit_acc = (I_PADDR == asx_pkg::REG_ACC);
  assign hit_status = (I_PADDR == asx_pkg::REG_STATUS);
  assign hit_wdog = (I_PADDR == asx_pkg::REG_WDOG);
  assign hit_file = aligned &&
    (I_PADDR[11:asx_pkg::FILE_PAGE_LSB] == asx_pkg::FILE_PAGE);
  assign mapped = hit_cmd || hit_acc || hit_status || hit_wdog || hit_file;
  assign file_idx = I_PADDR[8:2];

  // the core clock is stopped while asleep, so commands are turned away
  assign refused = hit_cmd && I_PWRITE && sleeping;
  assign exec = wr && hit_cmd && !sleeping;

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && (!mapped || refused);
  assign O_OSC_RUN = !sleeping;

  // command word fields; the unused op code 7 falls to the default branch
  assign cmd_op = asx_pkg::asx_op_e'(I_PWDATA[asx_pkg::CMD_OP_LSB +: asx_pkg::CMD_OP_W]);
  assign cmd_dest = I_PWDATA[asx_pkg::CMD_DEST_BIT];
  assign cmd_addr = I_PWDATA[asx_pkg::CMD_ADDR_LSB +: asx_pkg::FILE_IDX_W];
  assign cmd_lit = I_PWDATA[asx_pkg::CMD_LIT_LSB +: asx_pkg::DATA_W];
  assign fval = data_file[cmd_addr];

  asx_alu u_alu
  (
    .i_op(cmd_op),
    .i_acc(acc),
    .i_fval(fval),
    .i_lit(cmd_lit),
    .o_result(alu_res),
    .o_carry(alu_carry),
    .o_half_carry(alu_half),
    .o_upd_carry(alu_upd_carry),
    .o_upd_zero(alu_upd_zero),
    .o_reg_source(alu_reg_source)
  );

  // literal forms always land in the accumulator
  assign to_acc = (cmd_op == asx_pkg::OP_SUB_LIT_MINUS_ACC) ||
    (cmd_op == asx_pkg::OP_EXOR_LITERAL_ACC) || (alu_reg_source && !cmd_dest);
  assign to_file = alu_reg_source && cmd_dest;
  assign sleep_exec = exec && (cmd_op == asx_pkg::OP_SLEEP);

  asx_wdog u_wdog
  (
    .i_clock(I_CLOCK),
    .i_srst(I_SRST),
    .i_clear(sleep_exec),
    .o_prescaler(wd_prescaler),
    .o_count(wd_count)
  );

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      acc <= asx_pkg::ACC_RST;
    end
    else if (wr && hit_acc)
    begin
      acc <= I_PWDATA[7:0];
    end
    else if (exec && to_acc)
    begin
      acc <= alu_res;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      for (int i = 0; i < asx_pkg::FILE_DEPTH; i++)
      begin
        data_file[i] <= asx_pkg::FILE_RST;
      end
    end
    else if (wr && hit_file)
    begin
      data_file[file_idx] <= I_PWDATA[7:0];
    end
    else if (exec && to_file)
    begin
      data_file[cmd_addr] <= alu_res;
    end
  end

  // arithmetic flags: only the operations that own a flag touch it
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      carry <= 1'b0;
      half_carry <= 1'b0;
      zero <= 1'b0;
    end
    else if (wr && hit_status)
    begin
      carry <= I_PWDATA[asx_pkg::ST_CARRY];
      half_carry <= I_PWDATA[asx_pkg::ST_HALF_CARRY];
      zero <= I_PWDATA[asx_pkg::ST_ZERO];
    end
    else if (exec)
    begin
      if (alu_upd_carry)
      begin
        carry <= alu_carry;
        half_carry <= alu_half;
      end
      if (alu_upd_zero)
      begin
        zero <= (alu_res == 8'h00);
      end
    end
  end

  // power state flags are read-only to software
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      power_down_flag <= asx_pkg::POWER_DOWN_RST;
      time_out_flag <= asx_pkg::TIME_OUT_RST;
    end
    else if (sleep_exec)
    begin
      power_down_flag <= 1'b0;
      time_out_flag <= 1'b1;
    end
  end

  // wake-up is outside this unit; software stands in for it through the wake bit
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      sleeping <= 1'b0;
    end
    else if (sleep_exec)
    begin
      sleeping <= 1'b1;
    end
    else if (wr && hit_status && I_PWDATA[asx_pkg::ST_WAKE])
    begin
      sleeping <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      cmd_last <= 32'h0000_0000;
    end
    else if (exec)
    begin
      cmd_last <= I_PWDATA;
    end
  end

  // read data is fetched in the setup cycle so it leaves a flip-flop in the access cycle
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_cmd)
    begin
      next_prdata = cmd_last;
    end
    else if (hit_acc)
    begin
      next_prdata = {24'h00_0000, acc};
    end
    else if (hit_status)
    begin
      next_prdata[asx_pkg::ST_CARRY] = carry;
      next_prdata[asx_pkg::ST_HALF_CARRY] = half_carry;
      next_prdata[asx_pkg::ST_ZERO] = zero;
      next_prdata[asx_pkg::ST_POWER_DOWN] = power_down_flag;
      next_prdata[asx_pkg::ST_TIME_OUT] = time_out_flag;
      next_prdata[asx_pkg::ST_SLEEP] = sleeping;
    end
    else if (hit_wdog)
    begin
      next_prdata[asx_pkg::WDOG_CNT_W - 1:0] = wd_count;
      next_prdata[asx_pkg::WDOG_PRE_LSB +: asx_pkg::WDOG_PRE_W] = wd_prescaler;
    end
    else if (hit_file)
    begin
      next_prdata = {24'h00_0000, data_file[file_idx]};
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_PRDATA <= 32'h0000_0000;
    end
    else if (setup && !I_PWRITE)
    begin
      O_PRDATA <= next_prdata;
    end
  end

  // checking helpers, independent of the alu
  logic [7:0] chk_sub_reg;
  logic [7:0] chk_sub_lit;
  logic [7:0] chk_swap;
  logic [7:0] chk_xor_lit;
  logic [7:0] chk_xor_reg;
  logic [7:0] chk_minuend;
  logic chk_no_borrow;
  logic chk_no_half;
  logic chk_is_sub;
  logic chk_zero_exp;

  assign chk_sub_reg = fval - acc;
  assign chk_sub_lit = cmd_lit - acc;
  assign chk_swap = {fval[3:0], fval[7:4]};
  assign chk_xor_lit = acc ^ cmd_lit;
  assign chk_xor_reg = acc ^ fval;
  assign chk_is_sub = (cmd_op == asx_pkg::OP_SUB_REG_MINUS_ACC) ||
    (cmd_op == asx_pkg::OP_SUB_LIT_MINUS_ACC);
  assign chk_minuend = (cmd_op == asx_pkg::OP_SUB_LIT_MINUS_ACC) ? cmd_lit : fval;
  assign chk_no_borrow = !(acc > chk_minuend);
  assign chk_no_half = !(acc[3:0] > chk_minuend[3:0]);
  assign chk_zero_exp = (cmd_op == asx_pkg::OP_EXOR_LITERAL_ACC) ? (chk_xor_lit == 8'h00) :
    (cmd_op == asx_pkg::OP_EXOR_REG_ACC) ? (chk_xor_reg == 8'h00) :
    (cmd_op == asx_pkg::OP_SUB_LIT_MINUS_ACC) ? (chk_sub_lit == 8'h00) :
    (chk_sub_reg == 8'h00);

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);

  property p_sub_reg_acc;
    exec && cmd_op == asx_pkg::OP_SUB_REG_MINUS_ACC && !cmd_dest
      |=> acc == $past(chk_sub_reg);
  endproperty
  a_sub_reg_acc: assert property (p_sub_reg_acc)
    else $error("register minus accumulator result wrong");

  property p_sub_reg_file;
    exec && cmd_op == asx_pkg::OP_SUB_REG_MINUS_ACC && cmd_dest
      |=> data_file[$past(cmd_addr)] == $past(chk_sub_reg) && $stable(acc);
  endproperty
  a_sub_reg_file: assert property (p_sub_reg_file)
    else $error("register destination not honoured");

  property p_sub_lit;
    exec && cmd_op == asx_pkg::OP_SUB_LIT_MINUS_ACC |=> acc == $past(chk_sub_lit);
  endproperty
  a_sub_lit: assert property (p_sub_lit)
    else $error("literal minus accumulator result wrong");

  property p_borrow_flags;
    exec && chk_is_sub
      |=> carry == $past(chk_no_borrow) && half_carry == $past(chk_no_half);
  endproperty
  a_borrow_flags: assert property (p_borrow_flags)
    else $error("carry or half carry wrong after subtract");

  property p_sleep_flags;
    sleep_exec |=> !power_down_flag && time_out_flag ##1 !power_down_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("power-down or time-out flag wrong after sleep");

  property p_sleep_wdog;
    sleep_exec |=> wd_count == 8'h00 && wd_prescaler == 8'h00;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog)
    else $error("watchdog not cleared by sleep");

  property p_sleep_only;
    sleep_exec |=> !O_OSC_RUN && $stable(carry) && $stable(half_carry) && $stable(zero)
      && $stable(acc);
  endproperty
  a_sleep_only: assert property (p_sleep_only)
    else $error("sleep altered other state or left oscillator running");

  property p_swap;
    exec && cmd_op == asx_pkg::OP_NIBBLE_EXCHANGE && !cmd_dest
      |=> acc == $past(chk_swap) && $stable(carry) && $stable(zero) && $stable(half_carry);
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble exchange wrong");

  property p_xor_lit;
    exec && cmd_op == asx_pkg::OP_EXOR_LITERAL_ACC
      |=> acc == $past(chk_xor_lit) && $stable(carry) && $stable(half_carry);
  endproperty
  a_xor_lit: assert property (p_xor_lit)
    else $error("xor with literal wrong");

  property p_xor_reg;
    exec && cmd_op == asx_pkg::OP_EXOR_REG_ACC && cmd_dest
      |=> data_file[$past(cmd_addr)] == $past(chk_xor_reg) && $stable(carry) && $stable(acc);
  endproperty
  a_xor_reg: assert property (p_xor_reg)
    else $error("xor with register wrong");

  property p_zero;
    exec && (chk_is_sub || cmd_op == asx_pkg::OP_EXOR_LITERAL_ACC ||
      cmd_op == asx_pkg::OP_EXOR_REG_ACC) |=> zero == $past(chk_zero_exp);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  c_sub_to_file: cover property (exec && cmd_op == asx_pkg::OP_SUB_REG_MINUS_ACC && cmd_dest);
  c_sub_borrow: cover property (exec && chk_is_sub && !chk_no_borrow);
  c_xor_zero: cover property (exec && cmd_op == asx_pkg::OP_EXOR_LITERAL_ACC &&
    chk_xor_lit == 8'h00);
  c_sleep_refused: cover property (sleeping && wr && hit_cmd);
endmodule

// ### core/asx_pkg.sv
// constants, field layout and operation codes for the subtract/swap/xor/sleep unit
// assumes a 32-bit apb master and a single 125 MHz core clock
package asx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int FILE_DEPTH = 128;
  localparam int FILE_IDX_W = 7;

  // register byte offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ACC = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_WDOG = 12'h00C;
  // data file window: base + 4 * index, index 0..127
  localparam logic [2:0] FILE_PAGE = 3'h2;
  localparam int FILE_PAGE_LSB = 9;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_LIT_LSB = 16;

  // status word fields
  localparam int ST_CARRY = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_TIME_OUT = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_WAKE = 8;

  // watchdog read-back fields
  localparam int WDOG_CNT_W = 8;
  localparam int WDOG_PRE_W = 8;
  localparam int WDOG_PRE_LSB = 8;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic POWER_DOWN_RST = 1'b1;
  localparam logic TIME_OUT_RST = 1'b1;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_SUB_REG_MINUS_ACC,
    OP_SUB_LIT_MINUS_ACC,
    OP_NIBBLE_EXCHANGE,
    OP_EXOR_LITERAL_ACC,
    OP_EXOR_REG_ACC,
    OP_SLEEP
  } asx_op_e;
endpackage

// ### core/asx_alu.sv
// combinational datapath for the subtract, swap and exclusive-or operations
// assumes operands are stable for the cycle in which the caller commits the result
`timescale 1ns/1ps
module asx_alu
(
  input wire asx_pkg::asx_op_e i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_fval,
  input wire logic [7:0] i_lit,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_half_carry,
  output logic o_upd_carry,
  output logic o_upd_zero,
  output logic o_reg_source
);
  logic [7:0] minuend;

  always_comb
  begin
    minuend = (i_op == asx_pkg::OP_SUB_LIT_MINUS_ACC) ? i_lit : i_fval;
    o_result = 8'h00;
    o_carry = 1'b0;
    o_half_carry = 1'b0;
    o_upd_carry = 1'b0;
    o_upd_zero = 1'b0;
    o_reg_source = 1'b0;
    unique case (i_op)
      asx_pkg::OP_SUB_REG_MINUS_ACC, asx_pkg::OP_SUB_LIT_MINUS_ACC:
      begin
        o_result = minuend - i_acc;
        // carry is a no-borrow flag
        o_carry = (i_acc <= minuend);
        o_half_carry = (i_acc[3:0] <= minuend[3:0]);
        o_upd_carry = 1'b1;
        o_upd_zero = 1'b1;
        o_reg_source = (i_op == asx_pkg::OP_SUB_REG_MINUS_ACC);
      end
      asx_pkg::OP_NIBBLE_EXCHANGE:
      begin
        o_result = {i_fval[3:0], i_fval[7:4]};
        o_reg_source = 1'b1;
      end
      asx_pkg::OP_EXOR_LITERAL_ACC:
      begin
        o_result = i_acc ^ i_lit;
        o_upd_zero = 1'b1;
      end
      asx_pkg::OP_EXOR_REG_ACC:
      begin
        o_result = i_acc ^ i_fval;
        o_upd_zero = 1'b1;
        o_reg_source = 1'b1;
      end
      default:
      begin
        o_result = 8'h00;
      end
    endcase
  end
endmodule

// ### core/asx_wdog.sv
// watchdog prescaler and counter with a synchronous clear
// assumes one tick of the prescaler per core clock; wrap of the prescaler advances the counter
`timescale 1ns/1ps
module asx_wdog
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clear,
  output logic [7:0] o_prescaler,
  output logic [7:0] o_count
);
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_clear)
    begin
      o_prescaler <= 8'h00;
    end
    else
    begin
      o_prescaler <= o_prescaler + 8'h01;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_clear)
    begin
      o_count <= 8'h00;
    end
    else if (o_prescaler == 8'hFF)
    begin
      o_count <= o_count + 8'h01;
    end
  end
endmodule

// ### testbench/alu_sub_swap_xor_sleep_ops_bench.sv
// self-checking bench for the subtract/swap/xor/sleep unit, driven over apb
// assumes asx_core with pready tied high (zero wait states); bench still waits for it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module alu_sub_swap_xor_sleep_ops_bench;
  logic I_CLOCK = 1'b0;
  logic I_SRST = 1'b1;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0000_0000;
  logic [31:0] O_PRDATA;
  logic O_PREADY;
  logic O_PSLVERR;
  logic O_OSC_RUN;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  logic err;
  logic [31:0] q;
  logic [7:0] r;
  logic [7:0] sm [4] = '{8'h10, 8'h05, 8'h00, 8'h80};
  logic [7:0] sw [4] = '{8'h01, 8'h05, 8'h01, 8'h7F};
  logic [6:0] sx [4] = '{7'h00, 7'h7F, 7'h05, 7'h40};

  asx_core dut
  (
    .I_CLOCK(I_CLOCK),
    .I_SRST(I_SRST),
    .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR),
    .O_OSC_RUN(O_OSC_RUN)
  );

  initial
  begin
    forever #4 I_CLOCK = ~I_CLOCK;
  end

  // hang guard: generous ceiling over roughly 560 cycles of traffic
  always @(posedge I_CLOCK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge I_CLOCK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLOCK);
    I_PENABLE <= 1'b1;
    do
      @(posedge I_CLOCK);
    while (O_PREADY !== 1'b1);
    q = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] idx);
    return {asx_pkg::FILE_PAGE, idx, 2'b00};
  endfunction

  task automatic exec(input asx_pkg::asx_op_e op, input logic dst, input logic [6:0] idx,
                      input logic [7:0] lit);
    wr(asx_pkg::REG_CMD, {8'h00, lit, 1'b0, idx, 4'h0, dst, op});
  endtask

  task automatic chk8(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, q[7:0])
  endtask

  // expected {sleep, time-out, power-down, zero, half-carry, carry}
  task automatic chk_st(input logic [5:0] e);
    rd(asx_pkg::REG_STATUS);
    `CHK("status", e, q[5:0])
  endtask

  initial
  begin
    repeat (4) @(posedge I_CLOCK);
    I_SRST <= 1'b0;
    chk8("acc reset", asx_pkg::REG_ACC, 8'h00);
    chk8("file reset", fa(7'h7F), 8'h00);
    chk_st(6'h18);
    `CHK("osc reset", 1'b1, O_OSC_RUN)
    // register minus accumulator, borrow boundaries, both destinations
    for (int i = 0; i < 4; i++)
    begin
      r = sm[i] - sw[i];
      wr(fa(sx[i]), {24'h0, sm[i]});
      wr(asx_pkg::REG_ACC, {24'h0, sw[i]});
      exec(asx_pkg::OP_SUB_REG_MINUS_ACC, i[0], sx[i], 8'h00);
      chk8("sub reg dest", i[0] ? fa(sx[i]) : asx_pkg::REG_ACC, r);
      chk8("sub reg other", i[0] ? asx_pkg::REG_ACC : fa(sx[i]),
           i[0] ? sw[i] : sm[i]);
      chk_st({3'b011, r == 8'h00, sw[i][3:0] <= sm[i][3:0], sw[i] <= sm[i]});
    end
    // literal minus accumulator always lands in the accumulator
    for (int i = 0; i < 4; i++)
    begin
      r = sm[i] - sw[i];
      wr(asx_pkg::REG_ACC, {24'h0, sw[i]});
      exec(asx_pkg::OP_SUB_LIT_MINUS_ACC, 1'b1, 7'h00, sm[i]);
      chk8("sub lit acc", asx_pkg::REG_ACC, r);
      chk_st({3'b011, r == 8'h00, sw[i][3:0] <= sm[i][3:0],
              sw[i] <= sm[i]});
    end
    // nibble exchange leaves preset flags alone
    wr(asx_pkg::REG_STATUS, 32'h0000_0005);
    wr(fa(7'h03), 32'h0000_003C);
    exec(asx_pkg::OP_NIBBLE_EXCHANGE, 1'b1, 7'h03, 8'h00);
    chk8("swap file", fa(7'h03), 8'hC3);
    exec(asx_pkg::OP_NIBBLE_EXCHANGE, 1'b0, 7'h03, 8'h00);
    chk8("swap acc", asx_pkg::REG_ACC, 8'h3C);
    chk_st(6'h1D);
    // xor literal: only zero moves, both directions
    wr(asx_pkg::REG_STATUS, 32'h0000_0002);
    exec(asx_pkg::OP_EXOR_LITERAL_ACC, 1'b0, 7'h00, 8'h3C);
    chk8("xor lit zero", asx_pkg::REG_ACC, 8'h00);
    chk_st(6'h1E);
    exec(asx_pkg::OP_EXOR_LITERAL_ACC, 1'b0, 7'h00, 8'hFF);
    chk8("xor lit", asx_pkg::REG_ACC, 8'hFF);
    chk_st(6'h1A);
    // xor register to either destination
    wr(fa(7'h7F), 32'h0000_000F);
    exec(asx_pkg::OP_EXOR_REG_ACC, 1'b1, 7'h7F, 8'h00);
    chk8("xor reg file", fa(7'h7F), 8'hF0);
    chk8("xor reg acc kept", asx_pkg::REG_ACC, 8'hFF);
    exec(asx_pkg::OP_EXOR_REG_ACC, 1'b0, 7'h7F, 8'h00);
    chk8("xor reg acc", asx_pkg::REG_ACC, 8'h0F);
    wr(fa(7'h09), 32'h0000_000F);
    exec(asx_pkg::OP_EXOR_REG_ACC, 1'b0, 7'h09, 8'h00);
    chk_st(6'h1E);
    // no-op and the spare code touch nothing, but both are remembered as the last command
    exec(asx_pkg::OP_NOP, 1'b1, 7'h09, 8'hFF);
    exec(asx_pkg::asx_op_e'(3'h7), 1'b1, 7'h09, 8'hFF);
    chk8("nop acc", asx_pkg::REG_ACC, 8'h00);
    chk8("nop file", fa(7'h09), 8'h0F);
    chk_st(6'h1E);
    rd(asx_pkg::REG_CMD);
    `CHK("cmd readback", 32'h00FF_090F, q)
    // power-down after the watchdog has had time to advance
    wr(asx_pkg::REG_STATUS, 32'h0000_0005);
    wr(asx_pkg::REG_ACC, 32'h0000_005A);
    repeat (300) @(posedge I_CLOCK);
    rd(asx_pkg::REG_WDOG);
    `CHK("wdog running", 1'b1, q[7:0] != 8'h00)
    exec(asx_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00);
    @(negedge I_CLOCK);
    `CHK("osc halted", 1'b0, O_OSC_RUN)
    rd(asx_pkg::REG_WDOG);
    `CHK("wdog count", 8'h00, q[7:0])
    `CHK("wdog prescaler", 1'b1, q[15:8] < 8'h08)
    chk_st(6'h35);
    // commands are refused while asleep
    exec(asx_pkg::OP_EXOR_LITERAL_ACC, 1'b0, 7'h00, 8'hFF);
    `CHK("cmd asleep err", 1'b1, err)
    chk8("acc asleep", asx_pkg::REG_ACC, 8'h5A);
    rd(asx_pkg::REG_CMD);
    `CHK("cmd asleep kept", 32'h0000_0006, q)
    wr(asx_pkg::REG_STATUS, 32'h0000_0105);
    @(negedge I_CLOCK);
    `CHK("osc woken", 1'b1, O_OSC_RUN)
    chk_st(6'h15);
    `CHK("mapped err", 1'b0, err)
    // unmapped and misaligned addresses
    rd(12'h010);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, q)
    rd(12'h005);
    `CHK("misaligned err", 1'b1, err)
    final_report();
  end
endmodule
